// ---- rtl/aric_ack_detect.sv ----
// Standby pin high-low-high detector for alarm acknowledge.
`timescale 1ns/10ps
`default_nettype none
module aric_ack_detect #(
  parameter int LOW_CYCLES = 6250000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic levelOn,
  output logic ackPulse
);
  localparam int CW = $clog2(LOW_CYCLES + 1);
  aric_pkg::aric_ack_e state_q;
  aric_pkg::aric_ack_e state_d;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ack_d;
  logic ack_q;
  logic lowDone;
  assign lowDone = (count_q >= CW'(LOW_CYCLES - 1));
  always_comb begin
    state_d = state_q;
    count_d = '0;
    ack_d = 1'b0;
    case (state_q)
      aric_pkg::ARIC_ACK_WAIT: begin
        if (levelOn) begin
          state_d = aric_pkg::ARIC_ACK_HIGH;
        end
      end
      aric_pkg::ARIC_ACK_HIGH: begin
        if (!levelOn) begin
          state_d = aric_pkg::ARIC_ACK_LOW;
        end
      end
      aric_pkg::ARIC_ACK_LOW: begin
        count_d = count_q + CW'(1);
        if (levelOn) begin
          // A short low phase is a glitch and acknowledges nothing.
          state_d = aric_pkg::ARIC_ACK_HIGH;
        end else if (lowDone) begin
          state_d = aric_pkg::ARIC_ACK_LOWOK;
        end
      end
      aric_pkg::ARIC_ACK_LOWOK: begin
        if (levelOn) begin
          state_d = aric_pkg::ARIC_ACK_HIGH;
          ack_d = 1'b1;
        end
      end
      default: begin
        state_d = aric_pkg::ARIC_ACK_WAIT;
      end
    endcase
    if (!enable) begin
      state_d = aric_pkg::ARIC_ACK_WAIT;
      ack_d = 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= aric_pkg::ARIC_ACK_WAIT;
      count_q <= '0;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      ack_q <= ack_d;
    end
  end
  assign ackPulse = ack_q;
endmodule
`default_nettype wire

// ---- rtl/aric_ctrl.sv ----
// Analog remote interface control with a classic Wishbone register slave.
//****************************************************************
//****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "aric_defines.svh"
module aric_ctrl #(
  parameter int ACK_LOW_CYCLES = `ARIC_ACK_LOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic remoteSelPinN,
  input wire logic standbyAckPin,
  input wire logic digitalRemoteActive,
  input wire logic digitalRemoteReq,
  output logic digitalRemoteErr,
  input wire aric_pkg::aric_setpt_s analogPortIn,
  input wire aric_pkg::aric_val_t actualVoltage,
  input wire aric_pkg::aric_val_t actualCurrent,
  input wire aric_pkg::aric_alarm_s alarmIn,
  input wire logic constantVoltageState,
  output aric_pkg::aric_setpt_s setpointOut,
  output logic dcInputOn,
  output aric_pkg::aric_val_t voltageMonitorOut,
  output aric_pkg::aric_val_t currentMonitorOut,
  output aric_pkg::aric_val_t referenceOut,
  output logic alarm1Out,
  output logic alarm2Out,
  output logic statusOut,
  output logic analogRemoteActive,
  output logic alarmAckPulse
);
  //****************************************************************
  // Helpers
  //****************************************************************
  function automatic logic [15:0] monScale(input logic [15:0] v,
                                           input logic r10);
    logic [15:0] c;
    c = (v > `ARIC_FS_10V) ? `ARIC_FS_10V : v;
    monScale = r10 ? c : {1'b0, c[15:1]};
  endfunction
  function automatic logic [15:0] wbMerge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    wbMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  //****************************************************************
  // Registers and state
  //****************************************************************
  logic [`ARIC_CTRL_W-1:0] ctrl_q;
  logic [4:0] alarmEn_q;
  logic [15:0] limit_q [4];
  logic [15:0] local_q [4];
  aric_pkg::aric_alarm_s pend_q;
  aric_pkg::aric_alarm_s pend_d;
  logic err_q;
  logic errPulse_q;
  aric_pkg::aric_loc_e loc_q;
  aric_pkg::aric_loc_e loc_d;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  aric_pkg::aric_setpt_s setpt_q;
  aric_pkg::aric_setpt_s setpt_d;
  logic dcOn_q;
  logic [15:0] voltage_monitor_out_q;
  logic [15:0] current_monitor_out_q;
  logic [15:0] ref_q;
  logic alarm1_q;
  logic alarm2_q;
  logic status_q;

  //****************************************************************
  // Decoding
  //****************************************************************
  wire busReq = cyc_i && stb_i && !ack_q;
  wire busWr = busReq && we_i;
  wire [1:0] regSub = adr_i[3:2];
  wire selCtrl = (adr_i == `ARIC_OFF_CTRL);
  wire selAlmEn = (adr_i == `ARIC_OFF_ALMEN);
  wire selStatus = (adr_i == `ARIC_OFF_STATUS);
  wire selLimit = (adr_i[7:4] == 4'(`ARIC_OFF_LIMIT >> 4)) && !adr_i[1];
  wire selLocal = (adr_i[7:4] == 4'(`ARIC_OFF_LOCAL >> 4)) && !adr_i[1];
  wire selActive = (adr_i[7:4] == 4'(`ARIC_OFF_ACTIVE >> 4)) && !adr_i[1];
  wire isAnalog = (loc_q == aric_pkg::ARIC_LOC_ANALOG);
  wire range10V = ctrl_q[`ARIC_CTRL_R10V];
  wire sbOn = standbyAckPin ^ ctrl_q[`ARIC_CTRL_SBINV];
  wire anyAlarm = |pend_q;
  wire ackPulse;
  wire [15:0] portVal [4];
  wire [4:0] shownAlarm = pend_q & alarmEn_q;

  //****************************************************************
  // Port set value scaling
  //****************************************************************
  for (genvar g = 0; g < 4; g++) begin : gScale
    aric_scale uScale (
      .portCode(analogPortIn.val[g]),
      .range10V(range10V),
      .limit(limit_q[g]),
      .value(portVal[g])
    );
  end

  aric_ack_detect #(
    .LOW_CYCLES(ACK_LOW_CYCLES)
  ) uAck (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(isAnalog),
    .levelOn(sbOn),
    .ackPulse(ackPulse)
  );

  //****************************************************************
  // Control location
  //****************************************************************
  always_comb begin
    loc_d = loc_q;
    case (loc_q)
      aric_pkg::ARIC_LOC_MANUAL: begin
        if (!remoteSelPinN && digitalRemoteActive) begin
          loc_d = aric_pkg::ARIC_LOC_BLOCKED;
        end else if (!remoteSelPinN) begin
          loc_d = aric_pkg::ARIC_LOC_ANALOG;
        end
      end
      default: begin
        // The pin must go high again before a blocked entry can retry.
        if (remoteSelPinN) begin
          loc_d = aric_pkg::ARIC_LOC_MANUAL;
        end
      end
    endcase
  end

  //****************************************************************
  // Set values and alarms
  //****************************************************************
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      setpt_d.val[i] = isAnalog ? portVal[i] : local_q[i];
    end
    setpt_d.val[3] = (isAnalog && ctrl_q[`ARIC_CTRL_RMODE]) ?
                     portVal[3] : local_q[3];
  end
  // A new alarm in the acknowledge cycle stays pending.
  assign pend_d = (pend_q & ~{5{ackPulse}}) | alarmIn;

  //****************************************************************
  // Read multiplexer
  //****************************************************************
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (selCtrl) begin
      rdat_d[`ARIC_CTRL_W-1:0] = ctrl_q;
    end else if (selAlmEn) begin
      rdat_d[4:0] = alarmEn_q;
    end else if (selStatus) begin
      rdat_d[`ARIC_ST_ANALOG] = isAnalog;
      rdat_d[`ARIC_ST_DCON] = dcOn_q;
      rdat_d[`ARIC_ST_ALARM] = anyAlarm;
      rdat_d[`ARIC_ST_ERR] = err_q;
      rdat_d[`ARIC_ST_PEND +: 5] = pend_q;
    end else if (selLimit) begin
      rdat_d[15:0] = limit_q[regSub];
    end else if (selLocal) begin
      rdat_d[15:0] = local_q[regSub];
    end else if (selActive) begin
      rdat_d[15:0] = setpt_q.val[regSub];
    end
  end

  //****************************************************************
  // Bus slave and configuration
  //****************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= `ARIC_CTRL_RST;
      alarmEn_q <= `ARIC_ALMEN_RST;
      for (int i = 0; i < 4; i++) begin
        limit_q[i] <= `ARIC_LIMIT_RST;
        local_q[i] <= `ARIC_LOCAL_RST;
      end
    end else begin
      ack_q <= busReq;
      if (busReq) begin
        rdat_q <= rdat_d;
      end
      if (busWr && selCtrl && sel_i[0]) begin
        ctrl_q <= dat_i[`ARIC_CTRL_W-1:0];
      end
      if (busWr && selAlmEn && sel_i[0]) begin
        alarmEn_q <= dat_i[4:0];
      end
      if (busWr && selLimit) begin
        limit_q[regSub] <= wbMerge(limit_q[regSub], dat_i, sel_i);
      end
      if (busWr && selLocal) begin
        local_q[regSub] <= wbMerge(local_q[regSub], dat_i, sel_i);
      end
    end
  end

  //****************************************************************
  // Location, alarms and error flag
  //****************************************************************
  wire errSet = digitalRemoteReq && isAnalog;
  wire errClr = busWr && selStatus && sel_i[0] && dat_i[`ARIC_ST_ERR];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loc_q <= aric_pkg::ARIC_LOC_MANUAL;
      pend_q <= '0;
      err_q <= 1'b0;
      errPulse_q <= 1'b0;
    end else begin
      loc_q <= loc_d;
      pend_q <= pend_d;
      err_q <= errSet || (err_q && !errClr);
      errPulse_q <= errSet;
    end
  end

  //****************************************************************
  // Outputs
  //****************************************************************
  // Every range dependent output is loaded in one edge from one bit.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      setpt_q <= '0;
      dcOn_q <= 1'b0;
      voltage_monitor_out_q <= 16'h0000;
      current_monitor_out_q <= 16'h0000;
      ref_q <= 16'h0000;
      alarm1_q <= 1'b0;
      alarm2_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      setpt_q <= setpt_d;
      if (anyAlarm) begin
        dcOn_q <= 1'b0;
      end else if (isAnalog) begin
        dcOn_q <= sbOn;
      end else begin
        dcOn_q <= sbOn && ctrl_q[`ARIC_CTRL_DCON];
      end
      voltage_monitor_out_q <= monScale(actualVoltage, range10V);
      current_monitor_out_q <= monScale(actualCurrent, range10V);
      ref_q <= range10V ? `ARIC_FS_10V : `ARIC_FS_5V;
      alarm1_q <= shownAlarm[0] || shownAlarm[1];
      alarm2_q <= |shownAlarm[4:2];
      status_q <= !constantVoltageState;
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign digitalRemoteErr = errPulse_q;
  assign setpointOut = setpt_q;
  assign dcInputOn = dcOn_q;
  assign voltageMonitorOut = voltage_monitor_out_q;
  assign currentMonitorOut = current_monitor_out_q;
  assign referenceOut = ref_q;
  assign alarm1Out = alarm1_q;
  assign alarm2Out = alarm2_q;
  assign statusOut = status_q;
  assign analogRemoteActive = isAnalog;
  assign alarmAckPulse = ackPulse;
endmodule
`default_nettype wire

// ---- rtl/aric_defines.svh ----
// Constants of the analog remote interface control block.
`ifndef ARIC_DEFINES_SVH
`define ARIC_DEFINES_SVH
// Full-scale codes of the two input ranges.
`define ARIC_FS_10V 16'h6666
`define ARIC_FS_5V 16'h3333
// Timing of the standby acknowledge low phase.
`define ARIC_ACK_LOW_MS 50
`define ARIC_CLK_KHZ 125000
`define ARIC_ACK_LOW_CYCLES (`ARIC_ACK_LOW_MS * `ARIC_CLK_KHZ)
// Register byte offsets.
`define ARIC_OFF_CTRL 8'h00
`define ARIC_OFF_ALMEN 8'h04
`define ARIC_OFF_STATUS 8'h08
`define ARIC_OFF_LIMIT 8'h10
`define ARIC_OFF_LOCAL 8'h20
`define ARIC_OFF_ACTIVE 8'h30
`define ARIC_OFF_LAST 8'h3c
// Control register fields.
`define ARIC_CTRL_DCON 0
`define ARIC_CTRL_R10V 1
`define ARIC_CTRL_RMODE 2
`define ARIC_CTRL_SBINV 3
`define ARIC_CTRL_W 4
`define ARIC_CTRL_RST 4'h2
// Status register fields.
`define ARIC_ST_ANALOG 0
`define ARIC_ST_DCON 1
`define ARIC_ST_ALARM 2
`define ARIC_ST_ERR 3
`define ARIC_ST_PEND 4
// Reset values.
`define ARIC_ALMEN_RST 5'h1f
`define ARIC_LIMIT_RST 16'h6666
`define ARIC_LOCAL_RST 16'h0000
`endif

// ---- rtl/aric_pkg.sv ----
// Types shared by the analog remote interface control block.
package aric_pkg;
  typedef logic [15:0] aric_val_t;
  typedef struct packed {
    logic overpower;
    logic overcurrent;
    logic overvoltage;
    logic powerFail;
    logic overtemp;
  } aric_alarm_s;
  // Index 0 voltage, 1 current, 2 power, 3 resistance.
  typedef struct packed {
    aric_val_t [3:0] val;
  } aric_setpt_s;
  typedef enum logic {ARIC_RANGE_5V, ARIC_RANGE_10V} aric_range_e;
  typedef enum logic [1:0] {
    ARIC_LOC_MANUAL,
    ARIC_LOC_ANALOG,
    ARIC_LOC_BLOCKED
  } aric_loc_e;
  typedef enum logic [1:0] {
    ARIC_ACK_HIGH,
    ARIC_ACK_LOW,
    ARIC_ACK_LOWOK,
    ARIC_ACK_WAIT
  } aric_ack_e;
endpackage

// ---- rtl/aric_scale.sv ----
// Set value scaling and clipping for one analog port channel.
`timescale 1ns/10ps
`default_nettype none
`include "aric_defines.svh"
module aric_scale (
  input wire logic [15:0] portCode,
  input wire logic range10V,
  input wire logic [15:0] limit,
  output logic [15:0] value
);
  logic [15:0] fullScale;
  logic [15:0] clipped;
  logic [15:0] scaled;
  assign fullScale = range10V ? `ARIC_FS_10V : `ARIC_FS_5V;
  assign clipped = (portCode > fullScale) ? fullScale : portCode;
  // The 5 V range doubles its code, which keeps half the resolution.
  assign scaled = range10V ? clipped : {clipped[14:0], 1'b0};
  assign value = (scaled > limit) ? limit : scaled;
endmodule
`default_nettype wire

// ---- test/aric_ctrl_chk.sv ----
// Concurrent checks on the ports of the analog remote control block.
`timescale 1ns/10ps
`default_nettype none
module aric_ctrl_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic remoteSelPinN,
  input wire logic digitalRemoteActive,
  input wire logic digitalRemoteReq,
  input wire logic digitalRemoteErr,
  input wire aric_pkg::aric_alarm_s alarmIn,
  input wire aric_pkg::aric_setpt_s setpointOut,
  input wire logic dcInputOn,
  input wire aric_pkg::aric_val_t voltageMonitorOut,
  input wire aric_pkg::aric_val_t referenceOut,
  input wire logic analogRemoteActive,
  input wire logic alarmAckPulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  //****************************************************************
  // Assertions
  //****************************************************************
  chk_remote_entry: assert property ($rose(analogRemoteActive) |->
    !$past(remoteSelPinN) && !$past(digitalRemoteActive))
    else $error("analog entry without low select or with digital held");
  chk_manual_high: assert property (remoteSelPinN |=>
    !analogRemoteActive) else $error("analog kept with select high");
  chk_digital_err: assert property (!$past(reset) |->
    digitalRemoteErr == ($past(digitalRemoteReq) && $past(analogRemoteActive)))
    else $error("digital error pulse wrong");
  chk_ref_level: assert property (!$past(reset) |->
    referenceOut == 16'h6666 || referenceOut == 16'h3333)
    else $error("reference not a range full scale");
  chk_mon_range: assert property (voltageMonitorOut <= referenceOut)
    else $error("monitor above reference");
  chk_setpt_clip: assert property (analogRemoteActive ##1
    analogRemoteActive |-> setpointOut.val[0] <= 16'h6666 &&
    setpointOut.val[1] <= 16'h6666 && setpointOut.val[2] <= 16'h6666)
    else $error("set value above full scale");
  chk_alarm_off: assert property (|alarmIn |-> ##2 !dcInputOn)
    else $error("input on with alarm pending");
  chk_ack_pulse: assert property (alarmAckPulse |->
    $past(analogRemoteActive) && !$past(alarmAckPulse))
    else $error("acknowledge pulse out of place");
  chk_bus_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  cover property ($rose(analogRemoteActive));
  cover property (alarmAckPulse);
  cover property (digitalRemoteErr);
endmodule
bind aric_ctrl aric_ctrl_chk u_chk (.clk_sys(clk_sys), .reset(reset),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .remoteSelPinN(remoteSelPinN), .digitalRemoteActive(digitalRemoteActive),
  .digitalRemoteReq(digitalRemoteReq), .digitalRemoteErr(digitalRemoteErr),
  .alarmIn(alarmIn), .setpointOut(setpointOut), .dcInputOn(dcInputOn),
  .voltageMonitorOut(voltageMonitorOut), .referenceOut(referenceOut),
  .analogRemoteActive(analogRemoteActive), .alarmAckPulse(alarmAckPulse));
`default_nettype wire

// ---- test/aric_ctrl_model.sv ----
// Model of the external controller that drives the analog port pins.
`timescale 1ns/10ps
`default_nettype none
module aric_ctrl_model (
  input wire logic clk_sys,
  input wire logic wantRemote,
  input wire logic sbLevel,
  input wire aric_pkg::aric_setpt_s setVals,
  output logic remoteSelPinN,
  output logic standbyAckPin,
  output aric_pkg::aric_setpt_s analogPortIn
);
  initial begin
    remoteSelPinN = 1'b1;
    standbyAckPin = 1'b1;
    analogPortIn = '0;
  end
  always @(posedge clk_sys) begin
    remoteSelPinN <= !wantRemote;
    standbyAckPin <= sbLevel;
    if (wantRemote) begin
      analogPortIn <= setVals;
    end else begin
      // Unused inputs wander, so a stale value is never mistaken for data.
      analogPortIn <= ~analogPortIn;
    end
  end
endmodule
`default_nettype wire

// ---- test/test_aric_ctrl.sv ----
// Self-checking bench for the analog remote control block.
`timescale 1ns/10ps
`default_nettype none
module test_aric_ctrl;
  localparam int LOW = 20;
  logic clk_sys, reset, cyc, stb, we, wantRemote, sbLevel, digAct, digReq;
  logic ack_o, selN, sbPin, digErr, dcOn, al1, al2, stOut, anAct, ackP, cv;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, dat_o;
  aric_pkg::aric_setpt_s setVals, portIn, spOut;
  aric_pkg::aric_val_t actV, actI, voltage_monitor_out, current_monitor_out, refOut;
  aric_pkg::aric_alarm_s alarmIn;
  int fails, nCompared, cycles;
  aric_ctrl #(.ACK_LOW_CYCLES(LOW)) u_dut (.clk_sys(clk_sys), .reset(reset),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .sel_i(4'h3), .dat_o(dat_o), .ack_o(ack_o), .remoteSelPinN(selN),
    .standbyAckPin(sbPin), .digitalRemoteActive(digAct),
    .digitalRemoteReq(digReq), .digitalRemoteErr(digErr),
    .analogPortIn(portIn), .actualVoltage(actV), .actualCurrent(actI),
    .alarmIn(alarmIn), .constantVoltageState(cv), .setpointOut(spOut),
    .dcInputOn(dcOn), .voltageMonitorOut(voltage_monitor_out), .currentMonitorOut(current_monitor_out),
    .referenceOut(refOut), .alarm1Out(al1), .alarm2Out(al2),
    .statusOut(stOut), .analogRemoteActive(anAct), .alarmAckPulse(ackP));
  aric_ctrl_model u_model (.clk_sys(clk_sys), .wantRemote(wantRemote),
    .sbLevel(sbLevel), .setVals(setVals), .remoteSelPinN(selN),
    .standbyAckPin(sbPin), .analogPortIn(portIn));
  //****************************************************************
  // Shared tasks
  //****************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Outputs read right after an edge still show their settled pre-edge values.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("MISMATCH bus ack expected 1 seen 0");
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //****************************************************************
  // Scenarios
  //****************************************************************
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h0000_0002, rdat);
    wb(1'b0, 8'h04, 32'h0);
    chk("alarm enable", 32'h0000_001f, rdat);
    wb(1'b0, 8'h10, 32'h0);
    chk("limit", 32'h0000_6666, rdat);
    wb(1'b1, 8'h40, 32'h0000_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic t_manual;
    wb(1'b1, 8'h20, 32'h0000_1234);
    wb(1'b1, 8'h00, 32'h0000_0003);
    step(3);
    chk("manual set", 32'h0000_1234, 32'(spOut.val[0]));
    chk("manual on", 32'h1, 32'(dcOn));
    sbLevel <= 1'b0;
    step(4);
    chk("standby lock", 32'h0, 32'(dcOn));
    wb(1'b1, 8'h00, 32'h0000_000b);
    step(3);
    chk("standby invert", 32'h1, 32'(dcOn));
    sbLevel <= 1'b1;
    wb(1'b1, 8'h00, 32'h0000_0003);
  endtask
  task automatic t_analog;
    setVals <= {16'h3000, 16'h2000, 16'h1000, 16'h7000};
    wb(1'b1, 8'h14, 32'h0000_0800);
    wb(1'b1, 8'h2c, 32'h0000_0555);
    wantRemote <= 1'b1;
    step(5);
    chk("remote", 32'h1, 32'(anAct));
    chk("v clip", 32'h0000_6666, 32'(spOut.val[0]));
    chk("i limit", 32'h0000_0800, 32'(spOut.val[1]));
    chk("power", 32'h0000_2000, 32'(spOut.val[2]));
    chk("r local", 32'h0000_0555, 32'(spOut.val[3]));
    wb(1'b0, 8'h38, 32'h0);
    chk("shown power", 32'h0000_2000, rdat);
    wb(1'b1, 8'h00, 32'h0000_0006);
    step(3);
    chk("r port", 32'h0000_3000, 32'(spOut.val[3]));
  endtask
  task automatic t_range;
    actV <= 16'h4000;
    actI <= 16'h7000;
    cv <= 1'b1;
    setVals.val[0] <= 16'h1000;
    wb(1'b1, 8'h00, 32'h0000_0004);
    step(4);
    chk("ref 5V", 32'h0000_3333, 32'(refOut));
    chk("mon 5V", 32'h0000_2000, 32'(voltage_monitor_out));
    chk("set 5V", 32'h0000_2000, 32'(spOut.val[0]));
    chk("current_monitor_out 5V", 32'h0000_3333, 32'(current_monitor_out));
    chk("status cv", 32'h0, 32'(stOut));
    cv <= 1'b0;
    wb(1'b1, 8'h00, 32'h0000_0006);
    step(2);
    chk("ref 10V", 32'h0000_6666, 32'(refOut));
    chk("mon 10V", 32'h0000_4000, 32'(voltage_monitor_out));
    chk("current_monitor_out 10V", 32'h0000_6666, 32'(current_monitor_out));
    chk("status cc", 32'h1, 32'(stOut));
    chk("set 10V", 32'h0000_1000, 32'(spOut.val[0]));
  endtask
  task automatic t_digital;
    digReq <= 1'b1;
    step(1);
    digReq <= 1'b0;
    step(1);
    chk("dig err", 32'h1, 32'(digErr));
    wb(1'b0, 8'h08, 32'h0);
    chk("err flag", 32'h1, 32'(rdat[3]));
    wb(1'b1, 8'h08, 32'h0000_0008);
    wb(1'b0, 8'h08, 32'h0);
    chk("err clear", 32'h0, 32'(rdat[3]));
    wantRemote <= 1'b0;
    step(4);
    digAct <= 1'b1;
    wantRemote <= 1'b1;
    step(5);
    digAct <= 1'b0;
    step(3);
    chk("blocked", 32'h0, 32'(anAct));
    wantRemote <= 1'b0;
    step(3);
    wantRemote <= 1'b1;
    step(5);
  endtask
  task automatic t_alarm;
    int n;
    chk("remote on", 32'h1, 32'(dcOn));
    wb(1'b1, 8'h04, 32'h0000_001b);
    alarmIn <= 5'h05;
    step(1);
    alarmIn <= 5'h0;
    step(3);
    chk("alarm off", 32'h0, 32'(dcOn));
    chk("alarm1", 32'h1, 32'(al1));
    chk("masked", 32'h0, 32'(al2));
    sbLevel <= 1'b0;
    step(LOW / 2);
    sbLevel <= 1'b1;
    step(8);
    chk("short low", 32'h1, 32'(al1));
    sbLevel <= 1'b0;
    step(LOW + 5);
    sbLevel <= 1'b1;
    n = 0;
    while (ackP !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    chk("ack", 32'h1, 32'(ackP));
    step(3);
    chk("cleared", 32'h0, 32'(al1));
    chk("back on", 32'h1, 32'(dcOn));
    alarmIn <= 5'h0a;
    step(1);
    alarmIn <= 5'h0;
    step(3);
    chk("power fail", 32'h1, 32'(al1));
    chk("alarm2", 32'h1, 32'(al2));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("MISMATCH run length expected done seen timeout");
      give_verdict();
    end
  end
  initial begin
    {cyc, stb, we, wantRemote, digAct, digReq, cv} = '0;
    sbLevel = 1'b1;
    adr = 8'h00;
    wdat = 32'h0;
    setVals = '0;
    actV = 16'h0;
    actI = 16'h0;
    alarmIn = 5'h0;
    fails = 0;
    nCompared = 0;
    cycles = 0;
    reset = 1'b1;
    step(4);
    reset <= 1'b0;
    t_regs();
    t_manual();
    t_analog();
    t_range();
    t_digital();
    t_alarm();
    give_verdict();
  end
endmodule
`default_nettype wire
